/* File: rtl/imc_pkg.sv */
// Package: constants and carrier types of the input mapping and mode control
package imc_pkg;
    localparam int NUM_CH = 8;
    // Default channel attached to each direct input after reset
    localparam logic [7:0] MAP0_RST = 8'h04;
    localparam logic [7:0] MAP1_RST = 8'h08;
    localparam logic [7:0] OUT_RST  = 8'h00;
    localparam logic [7:0] PWMMAP_RST = 8'h00;
    localparam logic       ACT_RST  = 1'b0;
    localparam logic       PWMEN_RST = 1'b0;
    // Field positions in the write strobe vector
    localparam int WR_OUT   = 0;
    localparam int WR_MAP0  = 1;
    localparam int WR_MAP1  = 2;
    localparam int WR_PMAP0 = 3;
    localparam int WR_PMAP1 = 4;
    localparam int WR_CTRL  = 5;
    localparam int WR_N     = 6;

    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_IDLE  = 2'b01,
        MODE_ACT   = 2'b10,
        MODE_LIMP  = 2'b11
    } imc_mode_t;

    // Supply flags from the undervoltage detectors
    typedef struct packed {
        logic vsUnder;
        logic vddUnder;
    } imc_supply_t;

    // Register write request from the serial interface
    typedef struct packed {
        logic [WR_N-1:0] strobe;
        logic [7:0]      data;
    } imc_wr_t;
endpackage

/* File: rtl/imc_mode_ctrl.sv */
// Input mapping, channel drive combination and operating mode control
`timescale 1ns/10ps
module imc_mode_ctrl #(
    parameter int NCH = imc_pkg::NUM_CH
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic [1:0]          directInputN,
    input  wire logic                lowPowerN,
    input  wire imc_pkg::imc_supply_t supply,
    input  wire imc_pkg::imc_wr_t    wrReq,
    input  wire logic [1:0]          pwmGenOut,
    output logic [NCH-1:0]           chanDrive,
    output logic [1:0]               inputLevelMonitor,
    output imc_pkg::imc_mode_t       mode,
    output logic                     uvDetectEnable,
    output logic                     serialEnable,
    output logic [NCH-1:0]           outCtrl,
    output logic [NCH-1:0]           input0ChannelMap,
    output logic [NCH-1:0]           input1ChannelMap,
    output logic                     activeModeBit,
    output logic [1:0]               pwmGenEnable
);
    // Two-stage synchronisers; first stage read only by the second
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncA_q <= 3'h0;
            syncB_q <= 3'h0;
        end else begin
            syncA_q <= {lowPowerN, directInputN};
            syncB_q <= syncA_q;
        end
    end

    // Synchronised levels
    wire logic [1:0] inLvl    = syncB_q[1:0];
    wire logic       lpHigh   = syncB_q[2];
    wire logic       anyIn    = |inLvl;
    wire logic       sleepReq = !lpHigh && !anyIn;
    wire logic       limpReq  = !lpHigh && anyIn;
    // Registers held at default on pin low or logic supply low
    wire logic regClear = !lpHigh || supply.vddUnder;
    // Serial access refused with low-power pin low (sleep or fallback) or with logic supply low
    wire logic serOk = lpHigh && !supply.vddUnder;

    // Register state
    logic [NCH-1:0] out_q;
    logic [NCH-1:0] map0_q;
    logic [NCH-1:0] map1_q;
    logic [NCH-1:0] pmap0_q;
    logic [NCH-1:0] pmap1_q;
    logic           act_q;
    logic [1:0]     pwmEn_q;

    wire logic [imc_pkg::WR_N-1:0] wr = serOk ? wrReq.strobe : '0;
    wire logic [NCH-1:0] wdat = wrReq.data[NCH-1:0];

    // Register file; clear overrides writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_q   <= imc_pkg::OUT_RST;
            map0_q  <= imc_pkg::MAP0_RST;
            map1_q  <= imc_pkg::MAP1_RST;
            pmap0_q <= imc_pkg::PWMMAP_RST;
            pmap1_q <= imc_pkg::PWMMAP_RST;
            act_q   <= imc_pkg::ACT_RST;
            pwmEn_q <= {2{imc_pkg::PWMEN_RST}};
        end else if (regClear) begin
            out_q   <= imc_pkg::OUT_RST;
            map0_q  <= imc_pkg::MAP0_RST;
            map1_q  <= imc_pkg::MAP1_RST;
            pmap0_q <= imc_pkg::PWMMAP_RST;
            pmap1_q <= imc_pkg::PWMMAP_RST;
            act_q   <= imc_pkg::ACT_RST;
            pwmEn_q <= {2{imc_pkg::PWMEN_RST}};
        end else begin
            if (wr[imc_pkg::WR_OUT])   out_q   <= wdat;
            if (wr[imc_pkg::WR_MAP0])  map0_q  <= wdat;
            if (wr[imc_pkg::WR_MAP1])  map1_q  <= wdat;
            if (wr[imc_pkg::WR_PMAP0]) pmap0_q <= wdat;
            if (wr[imc_pkg::WR_PMAP1]) pmap1_q <= wdat;
            if (wr[imc_pkg::WR_CTRL]) begin
                act_q   <= wdat[0];
                pwmEn_q <= wdat[2:1];
            end
        end
    end

    // Gate a channel mask with one source level; shared by inputs and PWM
    function automatic logic [NCH-1:0] gateMap(input logic           en,
                                               input logic [NCH-1:0] m);
        gateMap = {NCH{en}} & m;
    endfunction

    // Drive combination; limp uses default map since registers are cleared
    wire logic [NCH-1:0] pwmDrv = gateMap(pwmGenOut[0] & pwmEn_q[0], pmap0_q)
                                | gateMap(pwmGenOut[1] & pwmEn_q[1], pmap1_q);
    wire logic [NCH-1:0] inDrv  = gateMap(inLvl[0], map0_q)
                                | gateMap(inLvl[1], map1_q);
    wire logic [NCH-1:0] drvRaw = out_q | pwmDrv | inDrv;
    // Main supply low forces all off; recovery is automatic
    wire logic [NCH-1:0] drv_d  = supply.vsUnder ? '0 : drvRaw;

    // Mode decision
    wire logic busy = act_q || (|out_q) || (|pwmEn_q);
    imc_pkg::imc_mode_t mode_d;
    always_comb begin
        case ({sleepReq, limpReq})
            2'b10:   mode_d = imc_pkg::MODE_SLEEP;
            2'b01:   mode_d = imc_pkg::MODE_LIMP;
            default: mode_d = busy ? imc_pkg::MODE_ACT
                                   : imc_pkg::MODE_IDLE;
        endcase
    end
    // Registered outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chanDrive         <= '0;
            inputLevelMonitor <= 2'h0;
            mode              <= imc_pkg::MODE_SLEEP;
            uvDetectEnable    <= 1'b0;
            serialEnable      <= 1'b0;
        end else begin
            chanDrive         <= drv_d;
            inputLevelMonitor <= inLvl;
            mode              <= mode_d;
            uvDetectEnable    <= !sleepReq;
            serialEnable      <= serOk;
        end
    end

    // Register copies for readback
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            outCtrl          <= '0;
            input0ChannelMap <= imc_pkg::MAP0_RST;
            input1ChannelMap <= imc_pkg::MAP1_RST;
            activeModeBit    <= 1'b0;
            pwmGenEnable     <= 2'h0;
        end else begin
            outCtrl          <= out_q;
            input0ChannelMap <= map0_q;
            input1ChannelMap <= map1_q;
            activeModeBit    <= act_q;
            pwmGenEnable     <= pwmEn_q;
        end
    end

    // Checks
    a_main_uv_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        supply.vsUnder |=> chanDrive == '0)
        else $error("channels on under main supply undervoltage");
    a_sleep_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        sleepReq |=> mode == imc_pkg::MODE_SLEEP && !uvDetectEnable)
        else $error("sleep not entered");
    a_limp_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        limpReq |=> mode == imc_pkg::MODE_LIMP)
        else $error("fallback mode not entered");
    a_reg_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        regClear |=> map0_q == imc_pkg::MAP0_RST && out_q == '0)
        else $error("registers not defaulted");
    a_serial_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        (sleepReq || supply.vddUnder) |=> !serialEnable)
        else $error("serial enabled while refused");
    a_monitor_lvl: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 inputLevelMonitor == $past(directInputN, 3))
        else $error("input monitor wrong");
    a_map_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!supply.vsUnder && inLvl[0] && map0_q[2]) |=> chanDrive[2])
        else $error("mapped input not driving");
    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##2 inLvl == $past(directInputN, 2))
        else $error("synchroniser delay wrong");

    // Low-power pin takes the same two-flop path as the inputs
    a_sync_lp: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##2 lpHigh == $past(lowPowerN, 2))
        else $error("low-power pin delay wrong");

    // Second map also returns to its default channel
    a_map1_default: assert property (@(posedge ref_clk) disable iff (!nrst)
        regClear |=> map1_q == imc_pkg::MAP1_RST)
        else $error("second map not defaulted");

    // PWM maps and control bits clear with the rest
    a_pwm_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        regClear |=> pmap0_q == imc_pkg::PWMMAP_RST
            && pmap1_q == imc_pkg::PWMMAP_RST
            && !act_q && pwmEn_q == 2'h0)
        else $error("control registers not defaulted");

    // A refused write never reaches the output bits
    a_write_refused: assert property (@(posedge ref_clk) disable iff (!nrst)
        !serOk |=> out_q == imc_pkg::OUT_RST)
        else $error("refused write landed");

    // Accepted map and output bit writes land at the strobe edge
    a_write_map0: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serOk && wrReq.strobe[imc_pkg::WR_MAP0])
            |=> map0_q == $past(wrReq.data))
        else $error("first map write lost");
    a_write_map1: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serOk && wrReq.strobe[imc_pkg::WR_MAP1])
            |=> map1_q == $past(wrReq.data))
        else $error("second map write lost");
    a_write_out: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serOk && wrReq.strobe[imc_pkg::WR_OUT])
            |=> out_q == $past(wrReq.data))
        else $error("output bit write lost");

    // Every set output bit reaches its channel
    a_out_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        !supply.vsUnder
            |=> (chanDrive & $past(out_q)) == $past(out_q))
        else $error("output bit not driving");

    // Second input reaches its default channel
    a_in1_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!supply.vsUnder && inLvl[1] && map1_q[3]) |=> chanDrive[3])
        else $error("second input not driving");

    // Enabled first PWM generator reaches all its mapped channels
    a_pwm_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!supply.vsUnder && pwmGenOut[0] && pwmEn_q[0])
            |=> (chanDrive & $past(pmap0_q)) == $past(pmap0_q))
        else $error("PWM generator not driving");

    // With no source at all every channel stays off
    a_no_source: assert property (@(posedge ref_clk) disable iff (!nrst)
        (out_q == '0 && inLvl == 2'h0 && pwmGenOut == 2'h0)
            |=> chanDrive == '0)
        else $error("channel on without source");

    // Fallback runs from the default maps
    a_limp_maps: assert property (@(posedge ref_clk) disable iff (!nrst)
        limpReq |=> map0_q == imc_pkg::MAP0_RST
            && map1_q == imc_pkg::MAP1_RST)
        else $error("fallback without default maps");

    // Detectors stay on in fallback, only sleep turns them off
    a_limp_uv_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        limpReq |=> uvDetectEnable)
        else $error("detectors off in fallback");

    // Idle and active chosen from the register state
    a_idle_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        (lpHigh && !busy) |=> mode == imc_pkg::MODE_IDLE)
        else $error("idle not chosen");
    a_active_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        (lpHigh && busy) |=> mode == imc_pkg::MODE_ACT)
        else $error("active not chosen");

    // Serial access is open whenever nothing refuses it
    a_serial_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        serOk |=> serialEnable)
        else $error("serial refused without cause");
    a_vdd_serial: assert property (@(posedge ref_clk) disable iff (!nrst)
        supply.vddUnder |=> !serialEnable)
        else $error("serial open with logic supply low");

    // Both supplies low: no drive and no serial access
    a_both_uv: assert property (@(posedge ref_clk) disable iff (!nrst)
        (supply.vsUnder && supply.vddUnder)
            |=> chanDrive == '0 && !serialEnable)
        else $error("activity with both supplies low");

    // Drive returns by itself once the main supply recovers
    a_uv_recover: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!supply.vsUnder && $past(supply.vsUnder) && out_q != '0)
            |=> chanDrive != '0)
        else $error("drive not restored");

    // Monitor keeps working in fallback and reads low in sleep
    a_monitor_limp: assert property (@(posedge ref_clk) disable iff (!nrst)
        limpReq |=> inputLevelMonitor != 2'h0)
        else $error("monitor dead in fallback");
    a_monitor_sleep: assert property (@(posedge ref_clk) disable iff (!nrst)
        sleepReq |=> inputLevelMonitor == 2'h0)
        else $error("monitor high in sleep");
endmodule // imc_mode_ctrl

/* File: sim/imc_host_model.sv */
// Host controller model driving the control pins and register writes
`timescale 1ns/10ps
module imc_host_model (
    input  wire logic        ref_clk,
    output logic [1:0]       directInputN,
    output logic             lowPowerN,
    output imc_pkg::imc_wr_t wrReq
);
    // Sleep request and no write at time zero
    initial begin
        directInputN = 2'h0;
        lowPowerN    = 1'b0;
        wrReq        = '0;
    end
    // Pin levels held long enough for the synchroniser and mode logic
    task automatic setPins(input logic lp, input logic [1:0] din);
        @(negedge ref_clk);
        lowPowerN    = lp;
        directInputN = din;
        repeat (5) @(negedge ref_clk);
    endtask
    // One-cycle strobe, then time for drive and readback to settle
    task automatic write(input int f, input logic [7:0] d);
        @(negedge ref_clk);
        wrReq.strobe = imc_pkg::WR_N'(1 << f);
        wrReq.data   = d;
        @(negedge ref_clk);
        wrReq.strobe = '0;
        repeat (3) @(negedge ref_clk);
    endtask
endmodule // imc_host_model

/* File: sim/test_imc_mode_ctrl.sv */
// Self-checking bench for input mapping and mode control
`timescale 1ns/10ps
module test_imc_mode_ctrl;
    logic                ref_clk;
    logic                nrst;
    logic [1:0]          directInputN;
    logic                lowPowerN;
    imc_pkg::imc_supply_t supply;
    imc_pkg::imc_wr_t    wrReq;
    logic [1:0]          pwmGenOut;
    logic [7:0]          chanDrive, outCtrl, map0, map1;
    logic [1:0]          inLvl, pwmEn;
    imc_pkg::imc_mode_t  mode;
    logic                uvEn, serEn, actBit;
    int                  errors = 0;
    int                  checked = 0;
    // 40 MHz clock; reset held six cycles
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        nrst = 1'b0; supply = '0; pwmGenOut = 2'h0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) nrst = 1'b1;
        tReset(); tMap(); tSupply(); tLowPower();
        summarize();
    end
    // Watchdog well beyond the fewer than a hundred cycles the tests need
    initial begin
        #100us errors++;
        summarize();
    end
    imc_host_model i_imc_host_model (.ref_clk(ref_clk),
        .directInputN(directInputN), .lowPowerN(lowPowerN), .wrReq(wrReq));
    imc_mode_ctrl i_imc_mode_ctrl (.ref_clk(ref_clk), .nrst(nrst),
        .directInputN(directInputN), .lowPowerN(lowPowerN),
        .supply(supply), .wrReq(wrReq), .pwmGenOut(pwmGenOut),
        .chanDrive(chanDrive), .inputLevelMonitor(inLvl), .mode(mode),
        .uvDetectEnable(uvEn), .serialEnable(serEn), .outCtrl(outCtrl),
        .input0ChannelMap(map0), .input1ChannelMap(map1),
        .activeModeBit(actBit), .pwmGenEnable(pwmEn));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tReset();
        chk(map0, 8'h04);
        chk(map1, 8'h08);
        chk(8'(mode), 8'(imc_pkg::MODE_SLEEP));
        chk(8'(uvEn), 8'h00);
    endtask
    // Inputs, remapping, output bits and PWM all OR into the drive
    task automatic tMap();
        i_imc_host_model.setPins(1'b1, 2'h1);
        chk(chanDrive, 8'h04);
        chk(8'(inLvl), 8'h01);
        chk(8'(mode), 8'(imc_pkg::MODE_IDLE));
        i_imc_host_model.write(imc_pkg::WR_MAP0, 8'h81);
        i_imc_host_model.setPins(1'b1, 2'h3);
        chk(chanDrive, 8'h89);
        i_imc_host_model.write(imc_pkg::WR_OUT, 8'h10);
        chk(chanDrive, 8'h99);
        chk(8'(mode), 8'(imc_pkg::MODE_ACT));
        i_imc_host_model.write(imc_pkg::WR_PMAP0, 8'h20);
        i_imc_host_model.write(imc_pkg::WR_CTRL, 8'h03);
        chk(8'(pwmEn), 8'h01);
        chk(8'(actBit), 8'h01);
        @(negedge ref_clk) pwmGenOut = 2'h1;
        repeat (3) @(negedge ref_clk);
        chk(chanDrive, 8'hB9);
    endtask
    // Supply flags: drive off, serial refused, registers back to default
    task automatic tSupply();
        supply.vsUnder = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(chanDrive, 8'h00);
        supply.vsUnder = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(chanDrive, 8'hB9);
        supply.vddUnder = 1'b1;
        i_imc_host_model.write(imc_pkg::WR_OUT, 8'h40);
        chk(outCtrl, 8'h00);
        chk(8'(serEn), 8'h00);
        chk(8'(pwmEn), 8'h00);
        supply = '1;
        repeat (4) @(negedge ref_clk);
        chk(chanDrive, 8'h00);
        supply = '0;
        repeat (4) @(negedge ref_clk);
        chk(chanDrive, 8'h0C);
    endtask
    // Low-power pin: fallback with an input high, sleep with both low
    task automatic tLowPower();
        i_imc_host_model.write(imc_pkg::WR_MAP0, 8'h01);
        i_imc_host_model.setPins(1'b0, 2'h1);
        chk(8'(mode), 8'(imc_pkg::MODE_LIMP));
        chk(chanDrive, 8'h04);
        chk(map0, 8'h04);
        chk(8'(inLvl), 8'h01);
        i_imc_host_model.setPins(1'b0, 2'h0);
        chk(8'(mode), 8'(imc_pkg::MODE_SLEEP));
        chk(8'(uvEn), 8'h00);
        i_imc_host_model.write(imc_pkg::WR_OUT, 8'h01);
        chk(outCtrl, 8'h00);
        chk(8'(serEn), 8'h00);
    endtask
    task automatic summarize();
        $display("errors %0d, checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
endmodule // test_imc_mode_ctrl
